// ==== pcm_pkg.sv ====
`default_nettype none
package pcm_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [31:0] OFS_CLK_CTRL   = 32'h0000_0000;
	localparam logic [31:0] OFS_UNLOCK_KEY = 32'h0000_0004;
	localparam logic [31:0] OFS_FS_INC     = 32'h0000_0008;
	localparam logic [31:0] OFS_FS_MINPER  = 32'h0000_000C;
	localparam logic [31:0] OFS_PHASE      = 32'h0000_0010;
	localparam logic [31:0] OFS_DUTY       = 32'h0000_0014;
	localparam logic [31:0] OFS_PERIOD     = 32'h0000_0018;
	localparam logic [31:0] OFS_GEN4_IO    = 32'h0000_001C;
	localparam logic [31:0] OFS_REMAP_SEL  = 32'h0000_0020;
	localparam logic [31:0] OFS_GEN_RUN    = 32'h0000_0024;

	// ----------------------------------------------------------------
	// field positions, keys, divider limits
	// ----------------------------------------------------------------
	localparam int          LOCK_BIT      = 8;
	localparam int          CLOCK_DIVIDER_SELECT_LSB    = 4;
	localparam int          SOURCE_CLOCK_SELECT_LSB   = 0;
	localparam int          HIGH_OUTPUT_PIN_ENABLE_BIT      = 3;
	localparam int          LOW_OUTPUT_PIN_ENABLE_BIT      = 2;
	localparam int          REMAP_H4_BIT  = 0;
	localparam int          DED_ALT_BIT   = 1;
	localparam int          NUM_GEN       = 4;
	localparam int          GEN4          = 3;
	localparam logic [7:0]  KEY_FIRST     = 8'h55;
	localparam logic [7:0]  KEY_SECOND    = 8'hAA;
	localparam logic [1:0]  CLOCK_DIVIDER_SELECT_16     = 2'h3;
	localparam logic [1:0]  CLOCK_DIVIDER_SELECT_8      = 2'h2;
	localparam logic [1:0]  CLOCK_DIVIDER_SELECT_4      = 2'h1;
	localparam logic [3:0]  DIV_LIM_16    = 4'hF;
	localparam logic [3:0]  DIV_LIM_8     = 4'h7;
	localparam logic [3:0]  DIV_LIM_4     = 4'h3;
	localparam logic [3:0]  DIV_LIM_2     = 4'h1;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		KEY_IDLE  = 3'b001,
		KEY_HALF  = 3'b010,
		KEY_ARMED = 3'b100
	} pcm_key_t;

	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} pcm_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pcm_axi_rsp_t;

	typedef struct packed {
		logic        ded_pin;
		logic        ded_oe;
		logic        rem_pin;
		logic        rem_oe;
		logic        low_oe;
	} pcm_g4pins_t;

	typedef struct packed {
		pcm_key_t          key;
		logic              lock;
		logic [1:0]        clock_divider_select;
		logic [1:0]        source_clock_select;
		logic [15:0]       freq_scale_increment;
		logic [15:0]       fsmin;
		logic [15:0]       phase;
		logic [15:0]       duty;
		logic [15:0]       period;
		logic [1:0]        io4;
		logic [1:0]        remap;
		logic [3:0]        run;
		logic [3:0]        div_cnt;
		logic [15:0]       acc;
		logic              fs_pulse;
		logic [3:0][15:0]  cnt;
		logic [3:0]        pwm_h;
		logic [3:0]        pwm_l;
		pcm_g4pins_t       pins;
		logic              aw_got;
		logic              w_got;
		logic [31:0]       awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		pcm_axi_rsp_t      rsp;
	} pcm_state_t;

endpackage
`default_nettype wire

// ==== pcm_top.sv ====
`default_nettype none
module pcm_top
	import pcm_pkg::*;
(
	// clock and reset
	input  wire logic          mclk_i,
	input  wire logic          rst_b_i,
	// register bus
	input  wire pcm_axi_req_t  axi_req_i,
	output logic               axi_rsp_o_awready,
	output var  pcm_axi_rsp_t  axi_rsp_o,
	// clock sources, one-cycle ticks
	input  wire logic [3:0]    src_tick_i,
	// other remapped function for dedicated pin
	input  wire logic          alt_fn_i,
	// generator outputs
	output logic [3:0]         pwm_h_o,
	output logic [3:0]         pwm_l_o,
	output logic               fscale_pulse_o,
	// generator4 pins
	output logic               ded_pin_o,
	output logic               ded_pin_oe_o,
	output logic               remap_pin_o,
	output logic               remap_pin_oe_o,
	output logic               gen4_low_oe_o
);

	// ----------------------------------------------------------------
	// state and combinational helpers
	// ----------------------------------------------------------------
	pcm_state_t  st_ff;
	pcm_state_t  nxt_st;
	logic        pwm_tick;
	logic        div_tick;
	logic [3:0]  div_lim;
	logic [16:0] fs_sum;
	logic        fs_exceed;
	logic        wr_fire;
	logic        ar_fire;

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	function automatic logic [32:0] read_mux(input pcm_state_t s, input logic [31:0] a);
		logic [32:0] r;
		r = '0;
		case (a)
			OFS_CLK_CTRL: begin
				r[LOCK_BIT] = s.lock;
				r[CLOCK_DIVIDER_SELECT_LSB +: 2] = s.clock_divider_select;
				r[SOURCE_CLOCK_SELECT_LSB +: 2] = s.source_clock_select;
			end
			OFS_UNLOCK_KEY: r = '0;
			OFS_FS_INC:     r[15:0] = s.freq_scale_increment;
			OFS_FS_MINPER:  r[15:0] = s.fsmin;
			OFS_PHASE:      r[15:0] = s.phase;
			OFS_DUTY:       r[15:0] = s.duty;
			OFS_PERIOD:     r[15:0] = s.period;
			OFS_GEN4_IO:    r[LOW_OUTPUT_PIN_ENABLE_BIT +: 2] = s.io4;
			OFS_REMAP_SEL:  r[1:0] = s.remap;
			OFS_GEN_RUN:    r[3:0] = s.run;
			default:        r[32] = 1'b1;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic [32:0] rd;
		logic [31:0] wa;
		logic        hit;
		rd = '0;
		wa = st_ff.awaddr;
		hit = 1'b1;
		nxt_st = st_ff;
		nxt_st.fs_pulse = 1'b0;

		pwm_tick = src_tick_i[st_ff.source_clock_select];
		case (st_ff.clock_divider_select)
			CLOCK_DIVIDER_SELECT_16: div_lim = DIV_LIM_16;
			CLOCK_DIVIDER_SELECT_8:  div_lim = DIV_LIM_8;
			CLOCK_DIVIDER_SELECT_4:  div_lim = DIV_LIM_4;
			default:   div_lim = DIV_LIM_2;
		endcase
		div_tick = pwm_tick && (st_ff.div_cnt >= div_lim);
		if (pwm_tick) begin
			nxt_st.div_cnt = div_tick ? '0 : st_ff.div_cnt + 4'h1;
		end

		fs_sum = {1'b0, st_ff.acc} + {1'b0, st_ff.freq_scale_increment};
		fs_exceed = fs_sum > {1'b0, st_ff.fsmin};
		if (pwm_tick) begin
			if (fs_exceed) begin
				nxt_st.fs_pulse = 1'b1;
				nxt_st.acc = '0;
			end else begin
				nxt_st.acc = fs_sum[15:0];
			end
		end

		for (int i = 0; i < NUM_GEN; i++) begin
			if (!st_ff.run[i]) begin
				nxt_st.cnt[i] = st_ff.phase;
				nxt_st.pwm_h[i] = 1'b0;
				nxt_st.pwm_l[i] = 1'b0;
			end else begin
				if (div_tick) begin
					nxt_st.cnt[i] = (st_ff.cnt[i] >= st_ff.period) ? '0
						: st_ff.cnt[i] + 16'h0001;
				end
				nxt_st.pwm_h[i] = st_ff.cnt[i] < st_ff.duty;
				nxt_st.pwm_l[i] = !(st_ff.cnt[i] < st_ff.duty);
			end
		end

		if (st_ff.remap[DED_ALT_BIT]) begin
			nxt_st.pins.ded_pin = alt_fn_i;
			nxt_st.pins.ded_oe = 1'b1;
		end else begin
			nxt_st.pins.ded_pin = nxt_st.pwm_h[GEN4];
			nxt_st.pins.ded_oe = st_ff.io4[HIGH_OUTPUT_PIN_ENABLE_BIT - LOW_OUTPUT_PIN_ENABLE_BIT];
		end
		nxt_st.pins.rem_pin = st_ff.remap[REMAP_H4_BIT] & nxt_st.pwm_h[GEN4];
		nxt_st.pins.rem_oe = st_ff.remap[REMAP_H4_BIT] & st_ff.io4[HIGH_OUTPUT_PIN_ENABLE_BIT - LOW_OUTPUT_PIN_ENABLE_BIT];
		nxt_st.pins.low_oe = st_ff.io4[0];

		// write channels taken in either order
		if (st_ff.rsp.awready && axi_req_i.awvalid) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = axi_req_i.awaddr;
		end
		if (st_ff.rsp.wready && axi_req_i.wvalid) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = axi_req_i.wdata;
			nxt_st.wstrb = axi_req_i.wstrb;
		end
		if (st_ff.rsp.bvalid && axi_req_i.bready) begin
			nxt_st.rsp.bvalid = 1'b0;
		end

		wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.rsp.bvalid;
		if (wr_fire) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.rsp.bvalid = 1'b1;
			// any write other than the key pair disarms the sequence
			nxt_st.key = KEY_IDLE;
			case (wa)
				OFS_UNLOCK_KEY: begin
					if (st_ff.wstrb[0] && st_ff.wdata[7:0] == KEY_FIRST) begin
						nxt_st.key = KEY_HALF;
					end else if (st_ff.wstrb[0] && st_ff.wdata[7:0] == KEY_SECOND
						&& st_ff.key == KEY_HALF) begin
						nxt_st.key = KEY_ARMED;
					end
				end
				OFS_CLK_CTRL: begin
					// the one write after the keys
					if (st_ff.key == KEY_ARMED && st_ff.wstrb[1]) begin
						nxt_st.lock = st_ff.wdata[LOCK_BIT];
					end
					if (!st_ff.lock && st_ff.wstrb[0]) begin
						nxt_st.clock_divider_select = st_ff.wdata[CLOCK_DIVIDER_SELECT_LSB +: 2];
						nxt_st.source_clock_select = st_ff.wdata[SOURCE_CLOCK_SELECT_LSB +: 2];
					end
				end
				OFS_GEN_RUN: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.run = st_ff.wdata[3:0];
					end
				end
				OFS_FS_INC, OFS_FS_MINPER, OFS_PHASE, OFS_DUTY, OFS_PERIOD,
				OFS_GEN4_IO, OFS_REMAP_SEL: begin
					if (!st_ff.lock) begin
						case (wa)
							OFS_FS_INC:    nxt_st.freq_scale_increment = merge16(st_ff.freq_scale_increment,
								st_ff.wdata, st_ff.wstrb);
							OFS_FS_MINPER: nxt_st.fsmin = merge16(st_ff.fsmin,
								st_ff.wdata, st_ff.wstrb);
							OFS_PHASE:     nxt_st.phase = merge16(st_ff.phase,
								st_ff.wdata, st_ff.wstrb);
							OFS_DUTY:      nxt_st.duty = merge16(st_ff.duty,
								st_ff.wdata, st_ff.wstrb);
							OFS_PERIOD:    nxt_st.period = merge16(st_ff.period,
								st_ff.wdata, st_ff.wstrb);
							OFS_GEN4_IO: begin
								if (st_ff.wstrb[0]) begin
									nxt_st.io4 = st_ff.wdata[LOW_OUTPUT_PIN_ENABLE_BIT +: 2];
								end
							end
							default: begin
								if (st_ff.wstrb[0]) begin
									nxt_st.remap = st_ff.wdata[1:0];
								end
							end
						endcase
					end
				end
				default: hit = 1'b0;
			endcase
			nxt_st.rsp.bresp = hit ? RESP_OKAY : RESP_SLVERR;
		end

		// read answers on the same edge that takes the address
		if (st_ff.rsp.rvalid && axi_req_i.rready) begin
			nxt_st.rsp.rvalid = 1'b0;
		end
		ar_fire = st_ff.rsp.arready && axi_req_i.arvalid;
		if (ar_fire) begin
			rd = read_mux(st_ff, axi_req_i.araddr);
			nxt_st.rsp.rvalid = 1'b1;
			nxt_st.rsp.rdata = rd[31:0];
			nxt_st.rsp.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
		end

		nxt_st.rsp.awready = !nxt_st.aw_got && !nxt_st.rsp.bvalid;
		nxt_st.rsp.wready = !nxt_st.w_got && !nxt_st.rsp.bvalid;
		nxt_st.rsp.arready = !nxt_st.rsp.rvalid;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			st_ff <= '0;
			st_ff.key <= KEY_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign axi_rsp_o = st_ff.rsp;
	assign axi_rsp_o_awready = st_ff.rsp.awready;
	assign pwm_h_o = st_ff.pwm_h;
	assign pwm_l_o = st_ff.pwm_l;
	assign fscale_pulse_o = st_ff.fs_pulse;
	assign ded_pin_o = st_ff.pins.ded_pin;
	assign ded_pin_oe_o = st_ff.pins.ded_oe;
	assign remap_pin_o = st_ff.pins.rem_pin;
	assign remap_pin_oe_o = st_ff.pins.rem_oe;
	assign gen4_low_oe_o = st_ff.pins.low_oe;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	property p_lock_key;
		(st_ff.lock != $past(st_ff.lock)) |-> $past(st_ff.key == KEY_ARMED && wr_fire);
	endproperty
	a_lock_key: assert property (p_lock_key) else $error("lock moved without keys");
	property p_locked_block;
		$past(wr_fire && st_ff.lock && st_ff.awaddr == OFS_PERIOD)
			|-> st_ff.period == $past(st_ff.period);
	endproperty
	a_locked_block: assert property (p_locked_block) else $error("locked write landed");
	property p_unlocked_write;
		$past(wr_fire && !st_ff.lock && st_ff.awaddr == OFS_DUTY && st_ff.wstrb[1:0] == 2'h3)
			|-> st_ff.duty == $past(st_ff.wdata[15:0]);
	endproperty
	a_unlocked_write: assert property (p_unlocked_write) else $error("duty write lost");
	property p_div16;
		(pwm_tick && st_ff.clock_divider_select == CLOCK_DIVIDER_SELECT_16 && st_ff.div_cnt != DIV_LIM_16)
			|=> st_ff.div_cnt == $past(st_ff.div_cnt) + 4'h1;
	endproperty
	a_div16: assert property (p_div16) else $error("divide by 16 wrong");
	property p_div8;
		(pwm_tick && st_ff.clock_divider_select == CLOCK_DIVIDER_SELECT_8 && st_ff.div_cnt == DIV_LIM_8)
			|=> st_ff.div_cnt == 4'h0;
	endproperty
	a_div8: assert property (p_div8) else $error("divide by 8 wrong");
	property p_src_sel;
		!src_tick_i[st_ff.source_clock_select] |=> st_ff.div_cnt == $past(st_ff.div_cnt);
	endproperty
	a_src_sel: assert property (p_src_sel) else $error("wrong clock source");
	property p_fs_pulse;
		$past(pwm_tick && fs_exceed) |-> fscale_pulse_o && st_ff.acc == 16'h0000;
	endproperty
	a_fs_pulse: assert property (p_fs_pulse) else $error("scaler pulse missing");
	property p_fs_acc;
		$past(pwm_tick && !fs_exceed) |-> !fscale_pulse_o
			&& st_ff.acc == $past(st_ff.acc) + $past(st_ff.freq_scale_increment);
	endproperty
	a_fs_acc: assert property (p_fs_acc) else $error("accumulator wrong");
	property p_phase;
		$past(!st_ff.run[0]) |-> st_ff.cnt[0] == $past(st_ff.phase);
	endproperty
	a_phase: assert property (p_phase) else $error("phase not loaded");
	property p_duty;
		$past(st_ff.run[0] && st_ff.cnt[0] < st_ff.duty) |-> pwm_h_o[0] && !pwm_l_o[0];
	endproperty
	a_duty: assert property (p_duty) else $error("duty compare wrong");
	property p_period;
		(st_ff.run[1] && div_tick && st_ff.cnt[1] >= st_ff.period) |=> st_ff.cnt[1] == 16'h0000;
	endproperty
	a_period: assert property (p_period) else $error("period wrap wrong");
	property p_both_pins;
		$past(st_ff.remap == 2'h1) |-> ded_pin_o == remap_pin_o && ded_pin_oe_o == remap_pin_oe_o;
	endproperty
	a_both_pins: assert property (p_both_pins) else $error("pins differ");
	property p_pin_gate;
		$past(!st_ff.io4[1] && !st_ff.remap[DED_ALT_BIT]) |-> !ded_pin_oe_o && !remap_pin_oe_o;
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("pin driven while disabled");
	property p_alt_wins;
		$past(st_ff.remap[DED_ALT_BIT]) |-> ded_pin_oe_o && ded_pin_o == $past(alt_fn_i);
	endproperty
	a_alt_wins: assert property (p_alt_wins) else $error("remapped function lost");
	property p_pair;
		(pwm_h_o & pwm_l_o) == 4'h0;
	endproperty
	a_pair: assert property (p_pair) else $error("high and low together");

endmodule // pcm_top
`default_nettype wire

// ==== pcm_placeholder_never.sv ====
`default_nettype none
`default_nettype wire

// ==== pcm_power_stage.sv ====
`default_nettype none
module pcm_power_stage
	import pcm_pkg::*;
(
	// clock and window clear
	input  wire logic              clk_i,
	input  wire logic              clr_i,
	// switch drive from the generators
	input  wire logic [3:0]        gate_h_i,
	// on-time of each high switch
	output logic [3:0][15:0]       on_cnt_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------
	// switch on-time integration
	// ------------------------------------------------

	// only counts cycles, so a glitch of one cycle is seen too
	// one leg per generator
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < NUM_GEN; i++) begin
			on_cnt_o[i] <= clr_i ? 16'h0000 : on_cnt_o[i] + 16'(gate_h_i[i]);
		end
	end

endmodule // pcm_power_stage
`default_nettype wire

// ==== pwm_common_clock_and_master_regs_tb.sv ====
`default_nettype none
module pwm_common_clock_and_master_regs_tb
	import pcm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic              mclk_i;
	logic              rst_b_i;
	pcm_axi_req_t      axi_req;
	pcm_axi_rsp_t      axi_rsp;
	logic [3:0]        src_tick;
	logic              alt_fn;
	logic [3:0]        pwm_h;
	logic [3:0]        pwm_l;
	logic              fs_pulse;
	logic              ded;
	logic              ded_oe;
	logic              rem;
	logic              rem_oe;
	logic              low_oe;
	logic              ps_clr;
	logic [3:0][15:0]  on_cnt;
	logic [31:0]       rd;
	logic [1:0]        rs;
	int                n;
	int                fails;
	int                tests_run;
	logic [15:0]       sc_inc [3] = '{16'h0004, 16'h0004, 16'hFFFF};
	logic [15:0]       sc_min [3] = '{16'h0007, 16'h000B, 16'h0007};
	logic [31:0]       sc_exp [3] = '{32'h0000_001E, 32'h0000_0014, 32'h0000_003C};

	initial mclk_i = 1'b0;
	always #2 mclk_i = ~mclk_i;

	pcm_top dut (
		.mclk_i            (mclk_i),
		.rst_b_i           (rst_b_i),
		.axi_req_i         (axi_req),
		.axi_rsp_o_awready (),
		.axi_rsp_o         (axi_rsp),
		.src_tick_i        (src_tick),
		.alt_fn_i          (alt_fn),
		.pwm_h_o           (pwm_h),
		.pwm_l_o           (pwm_l),
		.fscale_pulse_o    (fs_pulse),
		.ded_pin_o         (ded),
		.ded_pin_oe_o      (ded_oe),
		.remap_pin_o       (rem),
		.remap_pin_oe_o    (rem_oe),
		.gen4_low_oe_o     (low_oe)
	);

	pcm_power_stage ps (
		.clk_i    (mclk_i),
		.clr_i    (ps_clr),
		.gate_h_i (pwm_h),
		.on_cnt_o (on_cnt)
	);

	// ------------------------------------------------
	// bus tasks and checking
	// ------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge mclk_i);
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr  <= a;
		axi_req.wvalid  <= 1'b1;
		axi_req.wdata   <= d;
		axi_req.wstrb   <= 4'hF;
		axi_req.bready  <= 1'b1;
		forever begin
			@(posedge mclk_i);
			if (!aw && !w && axi_rsp.bvalid) begin
				rs = axi_rsp.bresp;
				axi_req.bready <= 1'b0;
				break;
			end
			if (aw && axi_rsp.awready) begin
				aw = 1'b0;
				axi_req.awvalid <= 1'b0;
			end
			if (w && axi_rsp.wready) begin
				w = 1'b0;
				axi_req.wvalid <= 1'b0;
			end
		end
	endtask

	task automatic rdr(input logic [31:0] a);
		logic ar;
		ar = 1'b1;
		@(posedge mclk_i);
		axi_req.arvalid <= 1'b1;
		axi_req.araddr  <= a;
		axi_req.rready  <= 1'b1;
		forever begin
			@(posedge mclk_i);
			if (!ar && axi_rsp.rvalid) begin
				rd = axi_rsp.rdata;
				rs = axi_rsp.rresp;
				axi_req.rready <= 1'b0;
				break;
			end
			if (ar && axi_rsp.arready) begin
				ar = 1'b0;
				axi_req.arvalid <= 1'b0;
			end
		end
	endtask

	task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
		rdr(a);
		chk(nm, rd, e);
	endtask

	task automatic keyed_ctrl(input logic [31:0] v);
		wr(OFS_UNLOCK_KEY, {24'h0, KEY_FIRST});
		wr(OFS_UNLOCK_KEY, {24'h0, KEY_SECOND});
		wr(OFS_CLK_CTRL, v);
	endtask

	// settle, then count pulses and switch on-time over a window
	task automatic window(input int cycles);
		repeat (4) @(posedge mclk_i);
		ps_clr <= 1'b1;
		@(posedge mclk_i);
		ps_clr <= 1'b0;
		n = 0;
		repeat (cycles) begin
			@(posedge mclk_i);
			n += int'(fs_pulse);
		end
		@(negedge mclk_i);
	endtask

	// ------------------------------------------------
	// test sequence
	// ------------------------------------------------
	initial begin
		fails = 0;
		tests_run = 0;
		axi_req = '0;
		src_tick = 4'h0;
		alt_fn = 1'b0;
		ps_clr = 1'b0;
		rst_b_i = 1'b0;
		repeat (20) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		for (int a = 0; a <= int'(OFS_GEN_RUN); a += 4) begin
			rc("reset value", 32'(a), 32'h0);
		end
		rdr(32'h0000_0040);
		chk("unmapped read", {rs, rd[29:0]}, {RESP_SLVERR, 30'h0});
		wr(32'h0000_0040, 32'h0000_FFFF);
		chk("unmapped write", {30'h0, rs}, {30'h0, RESP_SLVERR});
		wr(OFS_PHASE, 32'hFFFF_A5C3);
		rc("phase", OFS_PHASE, 32'h0000_A5C3);
		wr(OFS_CLK_CTRL, 32'h0000_0100);
		rc("unkeyed lock", OFS_CLK_CTRL, 32'h0);
		wr(OFS_UNLOCK_KEY, {24'h0, KEY_FIRST});
		wr(OFS_PHASE, 32'h0000_A5C3);
		wr(OFS_UNLOCK_KEY, {24'h0, KEY_SECOND});
		wr(OFS_CLK_CTRL, 32'h0000_0100);
		rc("broken key pair", OFS_CLK_CTRL, 32'h0);
		keyed_ctrl(32'h0000_0100);
		rc("keyed lock", OFS_CLK_CTRL, 32'h0000_0100);
		wr(OFS_PHASE, 32'h0000_0000);
		rc("locked phase", OFS_PHASE, 32'h0000_A5C3);
		wr(OFS_CLK_CTRL, 32'h0000_0000);
		rc("lock holds", OFS_CLK_CTRL, 32'h0000_0100);
		keyed_ctrl(32'h0000_0000);
		wr(OFS_PHASE, 32'h0000_0000);
		rc("unlocked phase", OFS_PHASE, 32'h0);
		wr(OFS_FS_INC, 32'h0000_0003);
		wr(OFS_FS_MINPER, 32'h0000_0007);
		for (int s = 0; s < 4; s++) begin
			wr(OFS_CLK_CTRL, 32'(s));
			src_tick <= 4'(1 << s);
			window(60);
			chk("selected source", 32'(n), 32'h0000_0014);
			@(posedge mclk_i);
			src_tick <= 4'(1 << ((s + 1) % 4));
			window(60);
			chk("other source", 32'(n), 32'h0000_0000);
		end
		wr(OFS_CLK_CTRL, 32'h0);
		src_tick <= 4'hF;
		for (int k = 0; k < 3; k++) begin
			wr(OFS_FS_INC, {16'h0, sc_inc[k]});
			wr(OFS_FS_MINPER, {16'h0, sc_min[k]});
			window(60);
			chk("scaler rate", 32'(n), sc_exp[k]);
		end
		wr(OFS_DUTY, 32'h0000_0008);
		wr(OFS_PERIOD, 32'h0000_0010);
		rc("duty", OFS_DUTY, 32'h0000_0008);
		rc("period", OFS_PERIOD, 32'h0000_0010);
		for (int d = 0; d < 4; d++) begin
			wr(OFS_GEN_RUN, 32'h0);
			repeat (2) @(negedge mclk_i);
			chk("stopped outputs", {24'h0, pwm_h, pwm_l}, 32'h0);
			wr(OFS_CLK_CTRL, 32'(d << 4));
			wr(OFS_GEN_RUN, 32'h0000_000F);
			repeat (34 << d) @(posedge mclk_i);
			window(68 << d);
			for (int g = 0; g < 4; g++) begin
				chk("high time", 32'(on_cnt[g]), 32'(32 << d));
			end
		end
		wr(OFS_GEN_RUN, 32'h0);
		wr(OFS_CLK_CTRL, 32'h0);
		wr(OFS_GEN_RUN, 32'h0000_000F);
		wr(OFS_GEN4_IO, 32'h0000_000C);
		wr(OFS_REMAP_SEL, 32'h0000_0001);
		repeat (40) begin
			@(negedge mclk_i);
			chk("routed pins", {26'h0, ded, ded_oe, rem, rem_oe, low_oe, pwm_l[3]},
				{26'h0, pwm_h[3], 1'b1, pwm_h[3], 2'b11, ~pwm_h[3]});
		end
		wr(OFS_GEN4_IO, 32'h0000_0004);
		@(negedge mclk_i);
		chk("gated pins", {29'h0, ded_oe, rem_oe, low_oe}, 32'h1);
		@(posedge mclk_i);
		alt_fn <= 1'b1;
		wr(OFS_GEN4_IO, 32'h0000_000C);
		wr(OFS_REMAP_SEL, 32'h0000_0003);
		repeat (2) @(negedge mclk_i);
		chk("alt on pin", {28'h0, ded, ded_oe, rem, rem_oe},
			{28'h0, 2'b11, pwm_h[3], 1'b1});
		summarize();
	end

	initial begin
		repeat (20000) @(posedge mclk_i);
		fails++;
		summarize();
	end

endmodule // pwm_common_clock_and_master_regs_tb
`default_nettype wire
